// ### verif/i2c_master_model.sv
// Behavioural I2C bus master pulling the clock and data wires low
`default_nettype none
module i2c_master_model #(
	// Bit period 3T: over twenty system clocks per bit, which the
	// longest debounce plus synchroniser delay needs on both lines
	parameter int T      = 200,
	parameter int GLITCH = 25
) (
	// Wire level and pull-low controls
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 100ps;
	// Both wires released until a frame begins
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// Phases span many system clocks; data moves mid-low, never near an edge
	task automatic bit_io(input logic b, output logic r);
		#T sda_low = !b;
		#T scl_low = 1'b0;
		#T r = sda;
		scl_low = 1'b1;
	endtask
	task start;
		sda_low = 1'b1;
		#T scl_low = 1'b1;
	endtask
	// A short release of the clock in its low phase; debounce must swallow it
	task spike;
		#(T / 2) scl_low = 1'b0;
		#GLITCH scl_low = 1'b1;
		#(T / 2);
	endtask
	task stop;
		#T sda_low = 1'b1;
		#T scl_low = 1'b0;
		#T sda_low = 1'b0;
		#T;
	endtask
	// Address or data out, top bit first, then sample the ack
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r); // Order
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]); // Order
		bit_io(!ack, r);
	endtask
endmodule // i2c_master_model
`default_nettype wire

// ### verif/i2c_slave_port_checker.sv
// Assertions on the I2C slave port pins and register views
`default_nettype none
module i2c_slave_port_checker (
	// APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Bus pins
	input wire logic        scl_in,
	input wire logic        scl_out,
	input wire logic        scl_oe,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        scl_pullup_en,
	input wire logic        sda_pullup_en,
	input wire logic        irq
);
	logic [9:0] mode_q;
	logic [7:0] own_q;
	wire        wr = psel && penable && pwrite;
	wire        rd = psel && penable && !pwrite;
	// Shadows of written words, so views can be judged without the body
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= 10'h0e0;
			own_q  <= 8'h00;
		end else if (wr && paddr == 12'h000) begin
			mode_q <= pwdata[9:0];
		end else if (wr && paddr == 12'h00c) begin
			own_q <= pwdata[7:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_scl_never_driven: assert property (!scl_oe) else $error("clock driven");
	chk_open_drain: assert property (!scl_out && !sda_out) else $error("pin high");
	chk_mode_read: assert property (rd && paddr == 12'h000 |-> prdata[9:0] == mode_q)
		else $error("mode word wrong");
	chk_addr_read: assert property (rd && paddr == 12'h00c |-> prdata[7:0] == own_q)
		else $error("own address wrong");
	chk_view_hidden: assert property (rd && paddr == 12'h004 && mode_q[7:4] != 4'hc |->
		prdata == 32'h0) else $error("status visible");
	chk_uart_hides: assert property (rd && paddr == 12'h010 && mode_q[4] |->
		prdata == 32'h0) else $error("timeout visible");
	chk_pullup_follow: assert property ({sda_pullup_en, scl_pullup_en} == mode_q[9:8])
		else $error("pull-up control lost");
	chk_irq_masked: assert property (wr && paddr == 12'h018 && pwdata[2:0] == 3'h0 |=> !irq)
		else $error("masked irq");
	chk_ack_in_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data moved with clock high");
	chk_off_silent: assert property (!mode_q[1] |=> !sda_oe) else $error("off yet driving");
	// Switching off: the write, then the data line left alone for two cycles
	sequence s_off_write;
		wr && paddr == 12'h000 && !pwdata[1];
	endsequence
	sequence s_line_free;
		!sda_oe [*2];
	endsequence
	chk_off_release: assert property (s_off_write |=> ##1 s_line_free)
		else $error("data line held after switch-off");
endmodule // i2c_slave_port_checker
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench of the I2C slave port against a master model
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk, presetn, psel, penable, pwrite, ack;
	logic [11:0] paddr;
	logic [31:0] pwdata, q;
	logic [7:0]  b;
	wire  [31:0] prdata;
	wire         pready, pslverr, scl_out, scl_oe, sda_out, sda_oe;
	wire         scl_pullup_en, sda_pullup_en, irq, m_scl_low, m_sda_low;
	int          n_errors, checks, cycles;
	// Pulled-up wires: any party pulling low wins
	wire scl_w = !((scl_oe && !scl_out) || m_scl_low);
	wire sda_w = !((sda_oe && !sda_out) || m_sda_low);
	i2c_slave_serial_port i2c_slave_serial_port_i (
		.pclk          (pclk),
		.presetn       (presetn),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.pready        (pready),
		.prdata        (prdata),
		.pslverr       (pslverr),
		.scl_in        (scl_w),
		.scl_out       (scl_out),
		.scl_oe        (scl_oe),
		.sda_in        (sda_w),
		.sda_out       (sda_out),
		.sda_oe        (sda_oe),
		.scl_pullup_en (scl_pullup_en),
		.sda_pullup_en (sda_pullup_en),
		.irq           (irq)
	);
	i2c_master_model i2c_master_model_i (.sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low));
	always #12.5 pclk = !pclk;
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), exp, q);
	endtask
	// Frames begin off the rising edge, so wire changes land mid-cycle until an APB access intervenes
	task begin_frame;
		@(negedge pclk);
		i2c_master_model_i.start();
	endtask
	task print_verdict;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// A hang ends the run as a failure
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict;
		end
	end
	task t_reset;
		rchk(12'h000, 32'he0); // Mode word
		rchk(12'h00c, 32'h0); // Address
		rchk(12'h004, 32'h0); // Status hidden
		rchk(12'h020, 32'h0);
	endtask
	task t_regs;
		apb(1'b1, 12'h00c, 32'h55);
		rchk(12'h00c, 32'h55); // Reserved bit kept
		apb(1'b1, 12'h000, 32'h30e);
		rchk(12'h000, 32'h30e); // Pull-ups
		chk("pullups", 32'h3, {sda_pullup_en, scl_pullup_en}); // Pins
		rchk(12'h004, 32'h0); // Status hidden
		apb(1'b1, 12'h000, 32'hd2);
		rchk(12'h004, 32'h0); // Uart wins
		rchk(12'h010, 32'h0); // Timeout hidden
	endtask
	task t_write(input logic [1:0] deb);
		apb(1'b1, 12'h000, {24'h0, 3'b110, 1'b0, deb, 2'b10});
		apb(1'b1, 12'h00c, 32'h54);
		apb(1'b1, 12'h010, 32'h5a);
		rchk(12'h010, 32'h5a); // Timeout shown in I2C mode
		apb(1'b1, 12'h018, 32'h7);
		begin_frame;
		i2c_master_model_i.wbyte(8'h54, ack);
		chk("address ack", 32'h1, ack); // Match
		if (deb != 2'h0) i2c_master_model_i.spike(); // Glitch swallowed
		i2c_master_model_i.wbyte(8'ha5 ^ {6'h0, deb}, ack);
		apb(1'b0, 12'h004, 32'h0);
		chk("status", 32'he1, q); // Done, matched, busy
		rchk(12'h008, {24'h0, 8'ha5 ^ {6'h0, deb}}); // Data
		i2c_master_model_i.stop();
		rchk(12'h014, 32'h7);
		@(negedge pclk);
		chk("irq raised", 32'h1, irq); // Level
		apb(1'b1, 12'h018, 32'h0);
		@(negedge pclk);
		chk("irq masked", 32'h0, irq); // Enable gates
		apb(1'b1, 12'h018, 32'h7);
		apb(1'b1, 12'h01c, 32'h7);
		@(negedge pclk);
		chk("irq cleared", 32'h0, irq); // Clear
	endtask
	task t_other;
		begin_frame;
		i2c_master_model_i.wbyte(8'h56, ack);
		chk("foreign ack", 32'h0, ack); // Other address
		i2c_master_model_i.stop();
		apb(1'b1, 12'h008, 32'h3c);
		begin_frame;
		i2c_master_model_i.wbyte(8'h55, ack);
		chk("read ack", 32'h1, ack); // Match
		i2c_master_model_i.rbyte(1'b0, b);
		chk("read byte", 32'h3c, b); // Transmit
		i2c_master_model_i.stop();
		apb(1'b1, 12'h000, 32'hc0);
		begin_frame;
		i2c_master_model_i.wbyte(8'h54, ack);
		chk("off ack", 32'h0, ack); // Switched off
		i2c_master_model_i.stop();
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_regs;
		for (int d = 0; d < 4; d++) t_write(d[1:0]);
		t_other;
		print_verdict;
	end
endmodule // testbench
bind i2c_slave_serial_port i2c_slave_port_checker i2c_slave_port_checker_i (
	.pclk          (pclk),
	.presetn       (presetn),
	.psel          (psel),
	.penable       (penable),
	.pwrite        (pwrite),
	.paddr         (paddr),
	.pwdata        (pwdata),
	.pready        (pready),
	.prdata        (prdata),
	.pslverr       (pslverr),
	.scl_in        (scl_in),
	.scl_out       (scl_out),
	.scl_oe        (scl_oe),
	.sda_in        (sda_in),
	.sda_out       (sda_out),
	.sda_oe        (sda_oe),
	.scl_pullup_en (scl_pullup_en),
	.sda_pullup_en (sda_pullup_en),
	.irq           (irq)
);
`default_nettype wire

// ### verilog/i2c_slave_port_defines.vh
// Register map, field positions, reset values and timing constants of the I2C slave port
`ifndef I2C_SLAVE_PORT_DEFINES_VH
`define I2C_SLAVE_PORT_DEFINES_VH

// Byte addresses on APB
`define OFS_MODE_CTRL     12'h000
`define OFS_STATUS_FLAGS  12'h004
`define OFS_SHIFT_DATA    12'h008
`define OFS_OWN_ADDR      12'h00c
`define OFS_TIMEOUT_CTRL  12'h010
`define OFS_IRQ_STATUS    12'h014
`define OFS_IRQ_ENABLE    12'h018
`define OFS_IRQ_CLEAR     12'h01c

// Reset values
`define RST_MODE_CTRL     8'he0
`define RST_OWN_ADDR      8'h00
`define RST_TIMEOUT_CTRL  8'h00

// Mode control fields
`define MODE_FIELD_HI     7
`define MODE_FIELD_LO     5
`define UART_SEL_BIT      4
`define DEB_HI            3
`define DEB_LO            2
`define ENABLE_BIT        1
`define SPI_INC_BIT       0

// Mode field codes
`define MODE_SPI_SLAVE    3'h5
`define MODE_I2C_SLAVE    3'h6
`define MODE_UNUSED       3'h7

// Debounce codes
`define DEB_NONE          2'h0
`define DEB_TWO           2'h1
`define DEB_TWO_CYCLES    3'h2
`define DEB_FOUR_CYCLES   3'h4

// Status flag bit positions
`define ST_BYTE_DONE      7
`define ST_ADDR_MATCH     6
`define ST_BUS_BUSY       5
`define ST_TX_SEL         4
`define ST_TX_NOACK       3
`define ST_READ_REQ       2
`define ST_WAKE_EN        1
`define ST_RX_NOACK       0

// Interrupt bit positions
`define IRQ_BYTE_DONE     0
`define IRQ_ADDR_MATCH    1
`define IRQ_STOP          2
`define IRQ_WIDTH         3

`endif

// ### verilog/i2c_slave_serial_port.v
// I2C slave port of the shared serial unit, with APB registers and interrupt
//
// The placing of the registers and register access over APB were left to the implementer.
`include "i2c_slave_port_defines.vh"
`default_nettype none

module i2c_slave_serial_port (
	// APB clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// I2C pins, open-drain
	input  wire        scl_in,
	output wire        scl_out,
	output wire        scl_oe,
	input  wire        sda_in,
	output wire        sda_out,
	output reg         sda_oe,
	// Pull-up controls for the two pins
	output reg         scl_pullup_en,
	output reg         sda_pullup_en,
	// Interrupt
	output wire        irq
);

	// Bus states
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_AACK = 3'h2;
	localparam ST_RX   = 3'h3;
	localparam ST_RACK = 3'h4;
	localparam ST_TX   = 3'h5;
	localparam ST_TACK = 3'h6;

	// Software registers
	reg  [7:0] mode_and_enable_control;
	reg  [7:0] shift_data;
	reg  [7:0] own_slave_address;
	reg  [7:0] timeout_control;
	reg        tx_sel;
	reg        tx_noack;
	reg        wake_en;
	// Hardware flags
	reg        byte_done_flag;
	reg        addr_match;
	reg        bus_busy;
	reg        read_req;
	reg        rx_noack;
	reg  [`IRQ_WIDTH-1:0] irq_status;
	reg  [`IRQ_WIDTH-1:0] irq_enable;

	// Mode decode
	wire       uart_select = mode_and_enable_control[`UART_SEL_BIT];
	wire [2:0] unit_mode_field = mode_and_enable_control[`MODE_FIELD_HI:`MODE_FIELD_LO];
	wire       unit_enable = mode_and_enable_control[`ENABLE_BIT];
	wire       i2c_mode = !uart_select && (unit_mode_field == `MODE_I2C_SLAVE);
	wire       active = i2c_mode && unit_enable;
	wire [1:0] clock_debounce_select = mode_and_enable_control[`DEB_HI:`DEB_LO];

	// Two-stage synchronisers on both bus lines
	reg  [1:0] scl_sync;
	reg  [1:0] sda_sync;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
		end
	end
	wire scl_s = scl_sync[1];
	wire sda_s = sda_sync[1];

	// Debounce length, forced to zero outside I2C mode
	reg  [2:0] deb_len;
	always @* begin
		if (!i2c_mode)
			deb_len = 3'h0;
		else if (clock_debounce_select == `DEB_NONE)
			deb_len = 3'h0;
		else if (clock_debounce_select == `DEB_TWO)
			deb_len = `DEB_TWO_CYCLES;
		else
			deb_len = `DEB_FOUR_CYCLES;
	end

	// Line filters: a new level must hold for deb_len system clocks.
	// Data passes the same filter as the clock so that both lag equally;
	// otherwise a data change in the low phase would reach the engine
	// while its filtered clock is still high and look like a start or stop.
	wire [1:0] line_s = {sda_s, scl_s};
	wire [1:0] line_f;
	genvar li;
	generate
		for (li = 0; li < 2; li = li + 1) begin : g_filter
			reg  [2:0] deb_cnt;
			reg        lvl;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					deb_cnt <= 3'h0;
					lvl <= 1'b1;
				end else if (line_s[li] == lvl) begin
					deb_cnt <= 3'h0;
				end else if (deb_cnt + 3'h1 >= deb_len) begin
					lvl <= line_s[li];
					deb_cnt <= 3'h0;
				end else begin
					deb_cnt <= deb_cnt + 3'h1;
				end
			end
			assign line_f[li] = lvl;
		end
	endgenerate
	wire scl_f = line_f[0];
	wire sda_f = line_f[1];

	// Delayed copies for edge detection
	reg scl_d;
	reg sda_d;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end
	wire scl_rise = scl_f && !scl_d;
	wire scl_fall = !scl_f && scl_d;
	wire start_det = active && scl_f && scl_d && sda_d && !sda_f;
	wire stop_det = active && scl_f && scl_d && !sda_d && sda_f;

	// APB decode, zero wait states
	wire apb_wr = psel && penable && pwrite;
	wire apb_rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	wire wr_ctrl = apb_wr && paddr == `OFS_MODE_CTRL;
	wire wr_stat = apb_wr && paddr == `OFS_STATUS_FLAGS && i2c_mode;
	wire wr_data = apb_wr && paddr == `OFS_SHIFT_DATA;
	wire wr_addr = apb_wr && paddr == `OFS_OWN_ADDR;
	wire rd_data = apb_rd && paddr == `OFS_SHIFT_DATA;

	// Shift engine
	reg  [2:0] state;
	reg  [3:0] bit_cnt;
	reg  [7:0] shreg;
	reg        byte_evt;
	reg        match_evt;
	wire [3:0] last_bit = 4'h8;
	wire       addr_hit = shreg[7:1] == own_slave_address[7:1];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			sda_oe <= 1'b0;
			addr_match <= 1'b0;
			read_req <= 1'b0;
			rx_noack <= 1'b1;
			bus_busy <= 1'b0;
			byte_evt <= 1'b0;
			match_evt <= 1'b0;
		end else begin
			byte_evt <= 1'b0;
			match_evt <= 1'b0;
			if (!active) begin
				state <= ST_IDLE;
				sda_oe <= 1'b0;
				bus_busy <= 1'b0;
				addr_match <= 1'b0;
			end else if (start_det) begin
				state <= ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe <= 1'b0;
				bus_busy <= 1'b1;
				addr_match <= 1'b0;
			end else if (stop_det) begin
				state <= ST_IDLE;
				sda_oe <= 1'b0;
				bus_busy <= 1'b0;
				addr_match <= 1'b0;
			end else begin
				case (state)
				ST_ADDR, ST_RX: begin
					// Sample on rising clock, MSB first
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_f};
						bit_cnt <= bit_cnt + 4'h1;
					end
					if (scl_fall && bit_cnt == last_bit) begin
						bit_cnt <= 4'h0;
						if (state == ST_ADDR) begin
							if (addr_hit) begin
								addr_match <= 1'b1;
								read_req <= shreg[0];
								match_evt <= 1'b1;
								sda_oe <= 1'b1;
								state <= ST_AACK;
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							byte_evt <= 1'b1;
							sda_oe <= !tx_noack;
							state <= ST_RACK;
						end
					end
				end
				ST_AACK, ST_RACK: begin
					// Release after the ninth clock; transmitter drives first bit
					if (scl_fall) begin
						if (state == ST_AACK && read_req) begin
							shreg <= shift_data;
							sda_oe <= !shift_data[7];
							state <= ST_TX;
						end else begin
							sda_oe <= 1'b0;
							state <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_rise)
						bit_cnt <= bit_cnt + 4'h1;
					if (scl_fall) begin
						if (bit_cnt == last_bit) begin
							sda_oe <= 1'b0;
							bit_cnt <= 4'h0;
							state <= ST_TACK;
						end else begin
							shreg <= {shreg[6:0], 1'b0};
							sda_oe <= !shreg[6];
						end
					end
				end
				ST_TACK: begin
					if (scl_rise) begin
						rx_noack <= sda_f;
						byte_evt <= 1'b1;
					end
					if (scl_fall) begin
						if (rx_noack) begin
							state <= ST_IDLE;
						end else begin
							shreg <= shift_data;
							sda_oe <= !shift_data[7];
							state <= ST_TX;
						end
					end
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// Open-drain: only pull low, never drive the clock
	assign sda_out = 1'b0;
	assign scl_out = 1'b0;
	assign scl_oe = 1'b0;

	// Byte done: cleared at start or data read or write, set on byte end, stop or while inactive
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			byte_done_flag <= 1'b1;
		else if (byte_evt || stop_det || !active)
			byte_done_flag <= 1'b1;
		else if (start_det || rd_data || wr_data)
			byte_done_flag <= 1'b0;
	end

	// Software registers; data register reset is arbitrary since its value is undefined
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_and_enable_control <= `RST_MODE_CTRL;
			own_slave_address <= `RST_OWN_ADDR;
			timeout_control <= `RST_TIMEOUT_CTRL;
			shift_data <= 8'h00;
			tx_sel <= 1'b0;
			tx_noack <= 1'b0;
			wake_en <= 1'b0;
			scl_pullup_en <= 1'b0;
			sda_pullup_en <= 1'b0;
		end else begin
			if (wr_ctrl)
				mode_and_enable_control <= pwdata[7:0];
			// Shared with the SPI second control register
			if (wr_addr)
				own_slave_address <= pwdata[7:0];
			if (apb_wr && paddr == `OFS_TIMEOUT_CTRL)
				timeout_control <= pwdata[7:0];
			if (wr_stat) begin
				tx_sel <= pwdata[`ST_TX_SEL];
				tx_noack <= pwdata[`ST_TX_NOACK];
				wake_en <= pwdata[`ST_WAKE_EN];
			end
			// Pull-ups stay writable whatever the mode
			if (wr_ctrl) begin
				scl_pullup_en <= pwdata[8];
				sda_pullup_en <= pwdata[9];
			end
			// The byte event is one cycle late, so the engine already sits in
			// the receive-ack state; transmit acks must not load the register
			if (byte_evt && state == ST_RACK)
				shift_data <= shreg;
			else if (wr_data)
				shift_data <= pwdata[7:0];
		end
	end

	// Sticky interrupt status; set wins over clear
	wire [`IRQ_WIDTH-1:0] irq_set = {stop_det, match_evt, byte_evt};
	wire [`IRQ_WIDTH-1:0] irq_clr = (apb_wr && paddr == `OFS_IRQ_CLEAR) ?
		pwdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= {`IRQ_WIDTH{1'b0}};
			irq_enable <= {`IRQ_WIDTH{1'b0}};
		end else begin
			irq_status <= irq_set | (irq_status & ~irq_clr);
			if (apb_wr && paddr == `OFS_IRQ_ENABLE)
				irq_enable <= pwdata[`IRQ_WIDTH-1:0];
		end
	end
	assign irq = |(irq_status & irq_enable);

	// Read mux; I2C views read zero outside I2C mode
	wire [7:0] status_flags = {byte_done_flag, addr_match, bus_busy, tx_sel,
		tx_noack, read_req, wake_en, rx_noack};
	always @* begin
		prdata = 32'h0;
		case (paddr)
		`OFS_MODE_CTRL:    prdata = {22'h0, sda_pullup_en, scl_pullup_en,
			mode_and_enable_control};
		`OFS_STATUS_FLAGS: prdata = i2c_mode ? {24'h0, status_flags} : 32'h0;
		`OFS_SHIFT_DATA:   prdata = {24'h0, shift_data};
		`OFS_OWN_ADDR:     prdata = {24'h0, own_slave_address};
		`OFS_TIMEOUT_CTRL: prdata = i2c_mode ? {24'h0, timeout_control} : 32'h0;
		`OFS_IRQ_STATUS:   prdata = {29'h0, irq_status};
		`OFS_IRQ_ENABLE:   prdata = {29'h0, irq_enable};
		default:           prdata = 32'h0;
		endcase
	end

endmodule // i2c_slave_serial_port
`default_nettype wire
